// >>> hw/pmrp_defines.svh
// constants and behaviour summary for the macrocell reset/preload block
// Behaviour
// - after power-up settle time, clear every macrocell flip-flop to 0
// - registered macrocell pins read high after power-up clear
// - registered macrocell array feedback reads low after power-up clear
// - power-up high pin level holds regardless of programmed polarity
// - both diagnostic pins elevated: flip-flops load from macrocell pins
// - during preload each flip-flop takes its pin's value
// - after preload, feedback shows the value loaded through the pin
// - two architecture bits per macrocell select its configuration
// - global configuration cell set whenever any macrocell is registered
// - cell set: clock pin and shared output enable; clear: both plain inputs
// - bidirectional cells use their direction term for three-state control
`ifndef PMRP_DEFINES_SVH
`define PMRP_DEFINES_SVH
`define PMRP_CLK_HZ 10000000
`define PMRP_SETTLE_NS 25
`define PMRP_SETTLE_CYC \
    ((`PMRP_SETTLE_NS * (`PMRP_CLK_HZ / 1000000) + 999) / 1000)
`define PMRP_PRELOAD_US 10
`define PMRP_PRELOAD_CYC (`PMRP_PRELOAD_US * (`PMRP_CLK_HZ / 1000000))
`define PMRP_ADDR_ARCH_A 12'h000
`define PMRP_ADDR_ARCH_B 12'h004
`define PMRP_ADDR_POLARITY 12'h008
`define PMRP_ADDR_STATUS 12'h00C
`define PMRP_ADDR_REGS 12'h010
`define PMRP_ARCH_A_RESET 8'h00
`define PMRP_ARCH_B_RESET 8'h00
`define PMRP_POL_RESET 8'h00
`define PMRP_STAT_CFG_BIT 0
`define PMRP_STAT_PRELOAD_BIT 1
`define PMRP_STAT_READY_BIT 2
`endif

// >>> hw/pmrp_pkg.sv
// types for the macrocell reset/preload block
`default_nettype none
package pmrp_pkg;
    typedef enum logic [1:0] {
        PMRP_BIDIR,
        PMRP_FIXED_IN,
        PMRP_FIXED_OUT,
        PMRP_REGISTERED
    } pmrp_mode_e;
    typedef enum logic [1:0] {
        PMRP_SETTLE,
        PMRP_RUN,
        PMRP_PRELOAD
    } pmrp_state_e;
    typedef struct packed {
        logic [7:0] arch_a;
        logic [7:0] arch_b;
        logic [7:0] polarity;
    } pmrp_cfg_s;
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe_n;
    } pmrp_pins_s;
endpackage
`default_nettype wire

// >>> hw/pmrp_sync3.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
module pmrp_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    initial begin
        if (WIDTH < 1) begin
            $error("pmrp_sync3 width must be positive");
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // bit changes only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/pmrp_core.sv
// macrocell register state: power-up clear, diagnostic preload, arch select
//
// The APB slave port and the register addresses were decided locally.
`include "pmrp_defines.svh"
`default_nettype none
module pmrp_core #(
    parameter int NCELL = 8,
    parameter int SETTLE_CYC = `PMRP_SETTLE_CYC,
    parameter int PRELOAD_CYC = `PMRP_PRELOAD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCELL-1:0] sum_term,
    input wire logic [NCELL-1:0] dir_term,
    input wire logic reg_clk_pin,
    input wire logic oe_n_pin,
    input wire logic diag_voltage_pin_a,
    input wire logic diag_voltage_pin_b,
    input wire logic [NCELL-1:0] macrocell_pins_i,
    output logic [NCELL-1:0] macrocell_pins_o,
    output logic [NCELL-1:0] macrocell_pins_oe_n,
    output logic [NCELL-1:0] array_feedback,
    output logic config_cell,
    output logic [1:0] dedicated_inputs
);
    import pmrp_pkg::*;
    initial begin
        if (NCELL < 1 || NCELL > 8 || SETTLE_CYC < 1 || PRELOAD_CYC < 1) begin
            $error("pmrp_core parameters out of range");
        end
    end
    function automatic pmrp_mode_e cell_mode(input logic a, input logic b);
        case ({a, b})
            2'b11: cell_mode = PMRP_REGISTERED;
            2'b01: cell_mode = PMRP_FIXED_IN;
            2'b10: cell_mode = PMRP_FIXED_OUT;
            default: cell_mode = PMRP_BIDIR;
        endcase
    endfunction
    pmrp_cfg_s cfg;
    pmrp_state_e state;
    logic [NCELL-1:0] q;
    logic [15:0] cnt;
    logic clk_s, oe_n_s, diag_a_s, diag_b_s;
    logic [NCELL-1:0] pin_s;
    logic clk_d;
    logic [NCELL-1:0] is_reg;
    logic any_reg;
    logic diag_on;
    logic clk_rise;
    pmrp_sync3 #(.WIDTH(NCELL + 4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din({reg_clk_pin, oe_n_pin, diag_voltage_pin_a, diag_voltage_pin_b,
              macrocell_pins_i}),
        .dout({clk_s, oe_n_s, diag_a_s, diag_b_s, pin_s})
    );
    for (genvar g = 0; g < NCELL; g++) begin : g_mode
        assign is_reg[g] = (cell_mode(cfg.arch_a[g], cfg.arch_b[g])
                            == PMRP_REGISTERED);
    end
    assign any_reg = |is_reg;
    assign diag_on = diag_a_s && diag_b_s;
    assign clk_rise = clk_s && !clk_d && any_reg;
    // apb: zero wait states, ready is a flop so it trails the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.arch_a <= `PMRP_ARCH_A_RESET;
            cfg.arch_b <= `PMRP_ARCH_B_RESET;
            cfg.polarity <= `PMRP_POL_RESET;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                `PMRP_ADDR_ARCH_A: cfg.arch_a <= pwdata[7:0];
                `PMRP_ADDR_ARCH_B: cfg.arch_b <= pwdata[7:0];
                `PMRP_ADDR_POLARITY: cfg.polarity <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
            case (paddr)
                `PMRP_ADDR_ARCH_A: prdata[7:0] <= cfg.arch_a;
                `PMRP_ADDR_ARCH_B: prdata[7:0] <= cfg.arch_b;
                `PMRP_ADDR_POLARITY: prdata[7:0] <= cfg.polarity;
                `PMRP_ADDR_STATUS: begin
                    prdata[`PMRP_STAT_CFG_BIT] <= any_reg;
                    prdata[`PMRP_STAT_PRELOAD_BIT] <= (state == PMRP_PRELOAD);
                    prdata[`PMRP_STAT_READY_BIT] <= (state != PMRP_SETTLE);
                end
                `PMRP_ADDR_REGS: prdata[NCELL-1:0] <= q;
                default: pslverr <= 1'b1;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d <= 1'b0;
        end else begin
            clk_d <= clk_s;
        end
    end
    // settle counter stands in for the power-up interval
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PMRP_SETTLE;
            cnt <= 16'h0000;
        end else begin
            case (state)
                PMRP_SETTLE: begin
                    if (cnt >= 16'(SETTLE_CYC - 1)) begin
                        state <= PMRP_RUN;
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                PMRP_RUN: begin
                    if (diag_on) begin
                        state <= PMRP_PRELOAD;
                        cnt <= 16'h0000;
                    end
                end
                PMRP_PRELOAD: begin
                    if (!diag_on) begin
                        state <= PMRP_RUN;
                    end else if (cnt != 16'hFFFF) begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                default: state <= PMRP_SETTLE;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (state == PMRP_SETTLE) begin
            q <= '0;
        end else if (state == PMRP_PRELOAD) begin
            q <= pin_s;
        end else if (clk_rise) begin
            for (int i = 0; i < NCELL; i++) begin
                if (is_reg[i]) begin
                    q[i] <= sum_term[i];
                end
            end
        end
    end
    // feedback: registered shows q, fixed output cut off, else pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_feedback <= '0;
        end else begin
            for (int i = 0; i < NCELL; i++) begin
                case (cell_mode(cfg.arch_a[i], cfg.arch_b[i]))
                    PMRP_REGISTERED: array_feedback[i] <= q[i];
                    PMRP_FIXED_OUT: array_feedback[i] <= 1'b0;
                    default: array_feedback[i] <= pin_s[i];
                endcase
            end
        end
    end
    // polarity ignored for registered cells so pins read high after clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            macrocell_pins_o <= '1;
            macrocell_pins_oe_n <= '1;
        end else begin
            for (int i = 0; i < NCELL; i++) begin
                case (cell_mode(cfg.arch_a[i], cfg.arch_b[i]))
                    PMRP_REGISTERED: begin
                        macrocell_pins_o[i] <= ~q[i];
                        macrocell_pins_oe_n[i] <= oe_n_s
                                                  || diag_on;
                    end
                    PMRP_BIDIR: begin
                        macrocell_pins_o[i] <= sum_term[i] ^ cfg.polarity[i];
                        macrocell_pins_oe_n[i] <= !dir_term[i];
                    end
                    PMRP_FIXED_OUT: begin
                        macrocell_pins_o[i] <= sum_term[i] ^ cfg.polarity[i];
                        macrocell_pins_oe_n[i] <= diag_on;
                    end
                    default: begin
                        macrocell_pins_o[i] <= 1'b1;
                        macrocell_pins_oe_n[i] <= 1'b1;
                    end
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_cell <= 1'b0;
            dedicated_inputs <= 2'b00;
        end else begin
            config_cell <= any_reg;
            dedicated_inputs <= any_reg ? 2'b00 : {clk_s, oe_n_s};
        end
    end
    clear_holds_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == PMRP_SETTLE |=> q == '0)
        else $error("flip-flops not cleared while settling");
    pin_high_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_reg[0] |=> macrocell_pins_o[0] == !$past(q[0]))
        else $error("registered pin not the inverse of its flip-flop");
    preload_load_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == PMRP_PRELOAD && diag_on |=> q == $past(pin_s))
        else $error("preload value not captured");
    feedback_reg_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_reg[0] ##1 is_reg[0] |-> array_feedback[0] == $past(q[0]))
        else $error("feedback does not follow register");
    fixed_out_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cell_mode(cfg.arch_a[0], cfg.arch_b[0]) == PMRP_FIXED_OUT
        |=> !array_feedback[0])
        else $error("fixed output feedback not cut");
    cfg_cell_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> config_cell == $past(any_reg))
        else $error("configuration cell wrong");
    bidir_dir_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cell_mode(cfg.arch_a[3], cfg.arch_b[3]) == PMRP_BIDIR
        |=> macrocell_pins_oe_n[3] == !$past(dir_term[3]))
        else $error("bidirectional enable not from direction term");
    capture_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == PMRP_RUN && !diag_on && clk_rise && is_reg[0]
        |=> q[0] == $past(sum_term[0]))
        else $error("rising clock did not capture sum term");
    enter_pl_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == PMRP_RUN && diag_on |=> state == PMRP_PRELOAD)
        else $error("preload not entered");
    preload_c: cover property (@(posedge pclk) state == PMRP_PRELOAD
        ##1 state == PMRP_RUN);
    capture_c: cover property (@(posedge pclk) clk_rise && is_reg != '0);
    settle_c: cover property (@(posedge pclk) state == PMRP_SETTLE
        ##1 state == PMRP_RUN);
    preload_len_c: cover property (@(posedge pclk) state == PMRP_PRELOAD
        && cnt == 16'(PRELOAD_CYC - 1));
endmodule
`default_nettype wire

// >>> testbench/pmrp_tester.sv
// tester model that drives the diagnostic preload sequence
`default_nettype none
module pmrp_tester #(
    parameter int HOLD = 100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [7:0] value,
    output logic diag_voltage_pin_a,
    output logic diag_voltage_pin_b,
    output logic [7:0] pins,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // pins held 8 cycles past the diag drop: the synced last load must match
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            busy <= 1'b0;
            pins <= 8'h00;
            diag_voltage_pin_a <= 1'b0;
            diag_voltage_pin_b <= 1'b0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            cnt <= 0;
            pins <= value;
            diag_voltage_pin_a <= 1'b1;
            diag_voltage_pin_b <= 1'b1;
        end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == HOLD) begin
                diag_voltage_pin_a <= 1'b0;
                diag_voltage_pin_b <= 1'b0;
            end
            if (cnt == HOLD + 8) begin
                busy <= 1'b0;
                pins <= ~pins; // released pins must not keep the loaded value
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/pld_macrocell_reset_preload_tb.sv
// self-checking bench for the macrocell reset/preload block
`default_nettype none
module pld_macrocell_reset_preload_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pmrp_pkg::*;
    localparam int PRE = 100;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic reg_clk_pin, oe_n_pin, start, busy, diag_a, diag_b, cfg;
    logic [7:0] sum_term, dir_term, tb_pins, tst_pins;
    logic [7:0] pins_o, oe_n, fb, pins_w;
    logic [1:0] ded;
    int errors, samples_checked, cyc;
    // pin wire: device drive where enabled, else tester or bench
    assign pins_w = (~oe_n & pins_o) | (oe_n & (busy ? tst_pins : tb_pins));

    pmrp_core #(.NCELL(8), .SETTLE_CYC(1), .PRELOAD_CYC(PRE)) i_pmrp_core (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sum_term(sum_term),
        .dir_term(dir_term), .reg_clk_pin(reg_clk_pin), .oe_n_pin(oe_n_pin),
        .diag_voltage_pin_a(diag_a), .diag_voltage_pin_b(diag_b),
        .macrocell_pins_i(pins_w), .macrocell_pins_o(pins_o),
        .macrocell_pins_oe_n(oe_n), .array_feedback(fb),
        .config_cell(cfg), .dedicated_inputs(ded));

    pmrp_tester #(.HOLD(PRE)) i_pmrp_tester (
        .pclk(pclk), .presetn(presetn), .start(start), .value(8'h3C),
        .diag_voltage_pin_a(diag_a), .diag_voltage_pin_b(diag_b),
        .pins(tst_pins), .busy(busy));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under 2000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, reg_clk_pin, start} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        oe_n_pin = 1'b1;
        sum_term = 8'h00;
        dir_term = 8'h00;
        tb_pins = 8'h00;
        wt(5);
        presetn <= 1'b1;
        wt(4);
        check(32'(oe_n), 32'hFF);
        check(32'(fb), 32'h00);
        rd_chk(12'h010, 32'h0);
        rd_chk(12'h00C, 32'h4);
        for (int i = 0; i < 3; i++) begin
            rd_chk(12'(4 * i), 32'h0);
        end
        rd_chk(12'h020, 32'h0);
        check(32'(err), 32'h1);
        // all cells registered, polarity flipped
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'(4 * i), 32'hFF);
            rd_chk(12'(4 * i), 32'hFF);
        end
        oe_n_pin <= 1'b0;
        wt(8);
        check(32'(cfg), 32'h1);
        check(32'(oe_n), 32'h00);
        check(32'(pins_o), 32'hFF);
        check(32'(ded), 32'h0);
        // clock capture, then a write to the read-only state word
        sum_term <= 8'hA5;
        reg_clk_pin <= 1'b1;
        wt(6);
        reg_clk_pin <= 1'b0;
        wt(6);
        apb(1'b1, 12'h010, 32'h00);
        rd_chk(12'h010, 32'hA5);
        check(32'(pins_o), 32'h5A);
        check(32'(fb), 32'hA5);
        // preload with outputs disabled, read back with them enabled
        oe_n_pin <= 1'b1;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        wt(20);
        rd_chk(12'h00C, 32'h7);
        check(32'(oe_n), 32'hFF);
        for (int k = 0; k < 300 && busy; k++) @(posedge pclk);
        check(32'(busy), 32'h0);
        oe_n_pin <= 1'b0;
        wt(8);
        rd_chk(12'h010, 32'h3C);
        check(32'(fb), 32'h3C);
        check(32'(pins_o), 32'hC3);
        check(32'(oe_n), 32'h00);
        // one cell of each mode: reg, fixed out, fixed in, bidir
        oe_n_pin <= 1'b1;
        tb_pins <= 8'hFF;
        dir_term <= 8'hFF;
        apb(1'b1, 12'h000, 32'h33);
        apb(1'b1, 12'h004, 32'h55);
        wt(8);
        check(32'(oe_n), 32'h55);
        check(32'(fb & 8'h22), 32'h0);
        dir_term <= 8'h00;
        wt(4);
        check(32'(oe_n), 32'hDD);
        // no registered cell: dedicated pins become plain inputs
        apb(1'b1, 12'h000, 32'h00);
        apb(1'b1, 12'h004, 32'h00);
        reg_clk_pin <= 1'b1;
        oe_n_pin <= 1'b0;
        wt(8);
        check(32'(cfg), 32'h0);
        check(32'(ded), 32'h2);
        sum_term <= 8'h00;
        reg_clk_pin <= 1'b0;
        wt(6);
        reg_clk_pin <= 1'b1;
        wt(6);
        rd_chk(12'h010, 32'h3C);
        // second power-up in mid-run
        presetn <= 1'b0;
        wt(2);
        check(32'(pins_o), 32'hFF);
        check(32'(fb), 32'h00);
        presetn <= 1'b1;
        wt(4);
        rd_chk(12'h010, 32'h0);
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b1, 12'h004, 32'hFF);
        wt(2);
        check(32'(pins_o), 32'hFF);
        check(32'(fb), 32'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
